/* hdl/nfc_cfg.svh */
// Constants of the NAND flash host controller: command codes, address layout, timing
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// Command codes
`define NFC_CMD_READ_HALF1 8'h00
`define NFC_CMD_READ_HALF2 8'h01
`define NFC_CMD_READ_SPARE 8'h50
`define NFC_IDENTIFICATION_READ_CMD 8'h90
`define NFC_CMD_RESET 8'hff
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_PROG_SETUP 8'h80
`define NFC_CMD_PROG_CONFIRM 8'h10
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_EXEC 8'hd0

// Address layout
`define NFC_ADDR_W 24
`define NFC_HALF_BIT 8
`define NFC_ADDR_CYCLES 2'h3
`define NFC_IDENT_ADDR_CYCLES 2'h1
`define NFC_ERASE_FIRST_CYCLE 2'h1
`define NFC_LEN_W 10

// Timing
`define NFC_CLK_PERIOD_NS 10
`define NFC_MIN_CYCLE_NS 50
`define NFC_WR_CYC_CLKS ((`NFC_MIN_CYCLE_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS)
`define NFC_WR_LO_CLKS 3
`define NFC_RD_CYC_CLKS 8
`define NFC_RD_LO_CLKS 6
`define NFC_BUSY_SETTLE_NS 100
`define NFC_BUSY_SETTLE_CLKS ((`NFC_BUSY_SETTLE_NS + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS)
`define NFC_PAGE_LOAD_US 10
`define NFC_PAGE_LOAD_CLKS ((`NFC_PAGE_LOAD_US * 1000) / `NFC_CLK_PERIOD_NS)

`endif

/* hdl/nfc_host_ctrl.sv */
// Host sequencer that drives a NAND flash through its command/address/data pins
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module nfc_host_ctrl
  import nfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // User command
  input wire logic cmd_valid_i,
  input wire nfc_op_t cmd_op_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic [9:0] cmd_len_i,
  output logic cmd_ready_o,
  // Program data in
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  // Read data out
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // Completion
  output logic done_o,
  output logic err_o,
  // Static controls
  input wire logic spare_enable_i,
  input wire logic write_enable_i,
  // Flash pins
  output logic flash_ce_n_o,
  output logic flash_cle_o,
  output logic flash_ale_o,
  output logic flash_we_n_o,
  output logic read_strobe_n_o,
  output logic flash_wp_n_o,
  output logic spare_area_select_o,
  input wire logic [7:0] flash_io_i,
  output logic [7:0] flash_io_o,
  output logic flash_io_oe_n_o,
  input wire logic flash_rb_i
);

  nfc_state_t state, next_state;
  nfc_op_t op, next_op;
  logic [23:0] addr, next_addr;
  logic [9:0] len, next_len;
  logic [3:0] ph, next_ph;
  logic [1:0] nadr, next_nadr;
  logic [10:0] cnt, next_cnt;
  logic [7:0] dbyte, next_dbyte;
  logic [7:0] next_rd_data;
  logic next_rd_valid, next_err;
  logic [7:0] io_level;
  logic rb_ready;
  logic [3:0] cyc_last;
  logic step_end, half_page_select_bit;
  logic [1:0] addr_end;
  logic [7:0] out_byte;
  logic next_ce_n, next_cle, next_ale, next_we_n, next_rd_strobe_n, next_oe_n;
  logic drive;

  // Data bus and ready/busy come from the flash, outside this clock
  nfc_pin_sync #(.WIDTH(8)) u_io_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(flash_io_i),
    .level_o(io_level)
  );
  nfc_pin_sync #(.WIDTH(1)) u_rb_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(flash_rb_i),
    .level_o(rb_ready)
  );

  // Handshakes
  assign cmd_ready_o = (state == S_IDLE);
  assign wr_ready_o = (state == S_WDATA) && (ph == 4'h0);
  assign done_o = (state == S_DONE);

  // Strobe cycle length and address span per operation
  assign cyc_last = (state == S_RDATA) ? 4'(`NFC_RD_CYC_CLKS - 1) : 4'(`NFC_WR_CYC_CLKS - 1);
  assign step_end = (ph == cyc_last);
  assign half_page_select_bit = addr[`NFC_HALF_BIT];
  assign addr_end = (op == OP_IDENT) ? `NFC_IDENT_ADDR_CYCLES : `NFC_ADDR_CYCLES;

  // Byte placed on the bus for command, address and data cycles
  always_comb
  begin
    out_byte = dbyte;
    if (state == S_CMD)
    begin
      unique case (op)
        OP_READ: out_byte = half_page_select_bit ? `NFC_CMD_READ_HALF2
                                                 : `NFC_CMD_READ_HALF1;
        OP_SPARE: out_byte = `NFC_CMD_READ_SPARE;
        OP_IDENT: out_byte = `NFC_IDENTIFICATION_READ_CMD;
        OP_RESET: out_byte = `NFC_CMD_RESET;
        OP_STATUS: out_byte = `NFC_CMD_STATUS;
        OP_PROGRAM: out_byte = `NFC_CMD_PROG_SETUP;
        OP_ERASE: out_byte = `NFC_CMD_ERASE_SETUP;
        default: out_byte = `NFC_CMD_STATUS;
      endcase
    end
    else if (state == S_CMD2)
    begin
      out_byte = (op == OP_ERASE) ? `NFC_CMD_ERASE_EXEC : `NFC_CMD_PROG_CONFIRM;
    end
    else if (state == S_ADDR)
    begin
      // Half-select bit never travels; bit 7 of the last row byte is forced low
      unique case (nadr)
        2'h0: out_byte = addr[7:0];
        2'h1: out_byte = addr[16:9];
        default: out_byte = {1'b0, addr[23:17]};
      endcase
    end
  end

  // Sequencer: one strobe cycle per command, address or data byte
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_len = len;
    next_ph = ph;
    next_nadr = nadr;
    next_cnt = cnt;
    next_dbyte = dbyte;
    next_rd_data = rd_data_o;
    next_rd_valid = 1'b0;
    next_err = err_o;
    unique case (state)
      S_IDLE:
      begin
        if (cmd_valid_i)
        begin
          next_op = cmd_op_i;
          next_addr = cmd_addr_i;
          next_len = cmd_len_i;
          next_ph = 4'h0;
          next_nadr = 2'h0;
          next_cnt = 11'h000;
          next_err = 1'b0;
          // Spare read refused while the spare area is switched off
          if (cmd_op_i == OP_SPARE && spare_area_select_o)
          begin
            next_err = 1'b1;
            next_state = S_DONE;
          end
          else
          begin
            next_state = S_CMD;
          end
        end
      end
      S_CMD:
      begin
        next_ph = ph + 4'h1;
        if (step_end)
        begin
          next_ph = 4'h0;
          unique case (op)
            OP_RESET: next_state = S_WAITB;
            OP_STATUS:
            begin
              next_len = 10'h001;
              next_state = S_RDATA;
            end
            OP_ERASE:
            begin
              next_nadr = `NFC_ERASE_FIRST_CYCLE;
              next_state = S_ADDR;
            end
            default: next_state = S_ADDR;
          endcase
        end
      end
      S_ADDR:
      begin
        next_ph = ph + 4'h1;
        if (step_end)
        begin
          next_ph = 4'h0;
          next_nadr = nadr + 2'h1;
          if (nadr + 2'h1 == addr_end)
          begin
            unique case (op)
              OP_IDENT: next_state = (len == 10'h000) ? S_DONE : S_RDATA;
              OP_PROGRAM: next_state = (len == 10'h000) ? S_CMD2 : S_WDATA;
              OP_ERASE: next_state = S_CMD2;
              default: next_state = S_WAITB;
            endcase
          end
        end
      end
      S_WDATA:
      begin
        // Stall before the strobe until a data byte is offered
        if (ph != 4'h0 || wr_valid_i)
        begin
          next_ph = ph + 4'h1;
        end
        if (ph == 4'h0 && wr_valid_i)
        begin
          next_dbyte = wr_data_i;
        end
        if (step_end)
        begin
          next_ph = 4'h0;
          next_len = len - 10'h001;
          if (len == 10'h001)
          begin
            next_state = S_CMD2;
          end
        end
      end
      S_CMD2:
      begin
        next_ph = ph + 4'h1;
        if (step_end)
        begin
          next_ph = 4'h0;
          next_cnt = 11'h000;
          next_state = S_WAITB;
        end
      end
      S_WAITB:
      begin
        // Let ready/busy fall and cross the synchroniser before trusting it
        if (cnt != 11'h7ff)
        begin
          next_cnt = cnt + 11'h001;
        end
        if (cnt >= 11'(`NFC_BUSY_SETTLE_CLKS) && rb_ready)
        begin
          next_state = ((op == OP_READ || op == OP_SPARE) && len != 10'h000) ? S_RDATA : S_DONE;
        end
        else if ((op == OP_READ || op == OP_SPARE) &&
                 cnt >= 11'(`NFC_BUSY_SETTLE_CLKS + `NFC_PAGE_LOAD_CLKS))
        begin
          next_err = 1'b1;
          next_state = S_DONE;
        end
      end
      S_RDATA:
      begin
        next_ph = ph + 4'h1;
        if (step_end)
        begin
          // Sample at the last low cycle of the read strobe
          next_ph = 4'h0;
          next_rd_data = io_level;
          next_rd_valid = 1'b1;
          next_len = len - 10'h001;
          if (len == 10'h001)
          begin
            next_state = S_DONE;
          end
        end
      end
      S_DONE: next_state = S_IDLE;
    endcase
  end

  // Pin decode, registered so every pin moves on the same edge
  always_comb
  begin
    drive = (state == S_CMD) || (state == S_ADDR) || (state == S_WDATA) || (state == S_CMD2);
    next_ce_n = (state == S_IDLE) || (state == S_DONE);
    next_cle = (state == S_CMD) || (state == S_CMD2);
    next_ale = (state == S_ADDR);
    next_we_n = !(drive && ph >= 4'h1 && ph <= 4'(`NFC_WR_LO_CLKS));
    next_rd_strobe_n = !(state == S_RDATA && ph >= 4'h1 && ph <= 4'(`NFC_RD_LO_CLKS));
    next_oe_n = !drive;
  end

  // State and pin registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      op <= OP_STATUS;
      addr <= 24'h000000;
      len <= 10'h000;
      ph <= 4'h0;
      nadr <= 2'h0;
      cnt <= 11'h000;
      dbyte <= 8'h00;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      err_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_cle_o <= 1'b0;
      flash_ale_o <= 1'b0;
      flash_we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      flash_io_o <= 8'h00;
      flash_io_oe_n_o <= 1'b1;
      flash_wp_n_o <= 1'b0;
      spare_area_select_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      len <= next_len;
      ph <= next_ph;
      nadr <= next_nadr;
      cnt <= next_cnt;
      dbyte <= next_dbyte;
      rd_data_o <= next_rd_data;
      rd_valid_o <= next_rd_valid;
      err_o <= next_err;
      flash_ce_n_o <= next_ce_n;
      flash_cle_o <= next_cle;
      flash_ale_o <= next_ale;
      flash_we_n_o <= next_we_n;
      read_strobe_n_o <= next_rd_strobe_n;
      flash_io_o <= out_byte;
      flash_io_oe_n_o <= next_oe_n;
      // Controls only change between operations, never mid-transfer
      if (state == S_IDLE)
      begin
        flash_wp_n_o <= write_enable_i;
        spare_area_select_o <= !spare_enable_i;
      end
    end
  end

  // Address strobes seen in the current operation, for the checks below
  logic we_q;
  logic [1:0] seen;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      we_q <= 1'b1;
      seen <= 2'h0;
    end
    else
    begin
      we_q <= flash_we_n_o;
      if (state == S_IDLE)
        seen <= 2'h0;
      else if (flash_we_n_o && !we_q && flash_ale_o)
        seen <= seen + 2'h1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_read_addr_count: assert property ($fell(read_strobe_n_o) && (op == OP_READ || op == OP_SPARE)
    |-> seen == 2'h3) else $error("page read without three address cycles");
  a_col_byte: assert property ($rose(flash_we_n_o) && flash_ale_o && seen == 2'h0
    && op != OP_ERASE |-> flash_io_o == addr[7:0]) else $error("column byte wrong");
  a_third_msb_low: assert property ($rose(flash_we_n_o) && flash_ale_o
    && (seen == 2'h2 || (op == OP_ERASE && seen == 2'h1)) |-> !flash_io_o[7])
    else $error("high row byte bit 7 not low");
  a_spare_guard: assert property ($rose(flash_we_n_o) && flash_cle_o
    && flash_io_o == 8'h50 |-> !spare_area_select_o) else $error("spare read while off");
  a_cmd_codes: assert property ($rose(flash_we_n_o) && flash_cle_o |-> flash_io_o inside
    {8'h00, 8'h01, 8'h50, 8'h90, 8'hff, 8'h70, 8'h80, 8'h10, 8'h60, 8'hd0})
    else $error("unknown command code");
  a_prog_confirm: assert property ($rose(flash_we_n_o) && flash_cle_o && flash_io_o == 8'h10
    |-> op == OP_PROGRAM && seen == 2'h3) else $error("stray program confirm");
  a_erase_exec: assert property ($rose(flash_we_n_o) && flash_cle_o && flash_io_o == 8'hd0
    |-> op == OP_ERASE && seen == 2'h2) else $error("erase execute out of order");
  a_strobe_select: assert property (!flash_we_n_o |-> !flash_ce_n_o && !flash_io_oe_n_o
    && read_strobe_n_o) else $error("write strobe without select");
  a_latch_excl: assert property (!(flash_cle_o && flash_ale_o))
    else $error("both latch qualifiers high");
  a_read_cycle: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o[*6]
    ##1 read_strobe_n_o[*2]) else $error("read strobe cycle wrong");
  a_read_ready: assert property ($fell(read_strobe_n_o) && (op == OP_READ || op == OP_SPARE)
    |-> rb_ready) else $error("page read before ready");

  c_page_read: cover property (rd_valid_o && done_o && op == OP_READ);
  c_program: cover property (done_o && op == OP_PROGRAM && !err_o);
  c_erase: cover property (done_o && op == OP_ERASE);
  c_spare_refused: cover property (done_o && op == OP_SPARE && err_o);

endmodule // nfc_host_ctrl

/* hdl/nfc_pin_sync.sv */
// Three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module nfc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pin in, filtered level out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Stage one feeds only stage two, so metastability never reaches a compare
  always_comb
  begin
    next_level = level_o;
    if (stage2 == stage3)
    begin
      next_level = stage3;
    end
  end

  // Shift chain and filtered level
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

endmodule // nfc_pin_sync

/* hdl/nfc_pkg.sv */
// Types of the NAND flash host controller
package nfc_pkg;

  // User operations
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_SPARE = 3'h1,
    OP_IDENT = 3'h2,
    OP_RESET = 3'h3,
    OP_STATUS = 3'h4,
    OP_PROGRAM = 3'h5,
    OP_ERASE = 3'h6
  } nfc_op_t;

  // Sequencer states, Gray coded along command, address, data, confirm, wait
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CMD = 3'h1,
    S_ADDR = 3'h3,
    S_WDATA = 3'h2,
    S_CMD2 = 3'h6,
    S_WAITB = 3'h7,
    S_RDATA = 3'h5,
    S_DONE = 3'h4
  } nfc_state_t;

endpackage

/* sim/nfc_flash_model.sv */
// Behavioural NAND flash that answers the host controller's pins
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int LOAD_NS = 1000,
  parameter int PROG_NS = 2000,
  parameter logic [7:0] ID0 = 8'h3c, // Arbitrary value
  parameter logic [7:0] ID1 = 8'h5a, // Arbitrary value
  parameter logic [7:0] STAT = 8'hc0
) (
  // Host-driven pins
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic spare_off_i,
  input wire logic [7:0] io_i,
  // Flash-driven pins
  output logic [7:0] io_o,
  output logic rb_o
);
  logic [7:0] mem [int];
  logic [7:0] preg [0:527];
  logic [7:0] cmd = 8'h00;
  logic [7:0] dout = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic half = 1'b0;
  logic busy = 1'b0;
  logic ld = 1'b0;
  int na = 0;
  int col = 0;
  int bns = 0;
  int k = 0;
  event kick;

  // Ready pin, pulled up while idle
  assign rb_o = !busy;
  // Released bus shows the inverse so stale data cannot pass as a read
  assign io_o = (!ce_n_i && !read_strobe_n_i) ? dout : ~dout;

  function automatic int key(input logic [14:0] row, input int c);
    return int'(row) * 528 + c;
  endfunction

  function automatic logic [7:0] rdm(input int kk);
    return mem.exists(kk) ? mem[kk] : 8'hff;
  endfunction

  task automatic start_busy(input int ns, input logic load);
    bns = ns;
    ld = load;
    -> kick;
  endtask

  // Page load lands only at the end of busy, so early reads get stale bytes
  always @(kick)
  begin
    busy = 1'b1;
    #(bns);
    for (int c = 0; c < 528 && ld; c++)
      preg[c] = rdm(key(adr[23:9], c));
    busy = 1'b0;
  end

  // Command, address and data latch on the write strobe rise
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && cle_i)
    begin
      if ((!busy || io_i == 8'hff || io_i == 8'h70) && !(io_i == 8'h50 && spare_off_i))
      begin
        cmd = io_i;
        na = 0;
        if (io_i == 8'h00 || io_i == 8'h01)
          half = io_i[0];
        for (int c = 0; c < 528 && io_i == 8'h80; c++)
          preg[c] = 8'hff;
        for (int c = 0; c < 528 && io_i == 8'h10 && wp_n_i; c++)
          mem[key(adr[23:9], c)] = rdm(key(adr[23:9], c)) & preg[c];
        for (int c = 0; c < 32 * 528 && io_i == 8'hd0 && wp_n_i; c++)
          mem.delete(key({adr[23:14], 5'(c / 528)}, c % 528));
        if ((io_i == 8'h10 || io_i == 8'hd0) && wp_n_i)
          start_busy(PROG_NS, 1'b0);
        if (io_i == 8'hff)
          start_busy(100, 1'b0);
        if (io_i == 8'h70)
          dout = STAT;
      end
    end
    else if (!ce_n_i && ale_i)
    begin
      k = (cmd == 8'h60) ? na + 1 : na;
      if (k == 0)
        adr[7:0] = io_i;
      if (k == 1)
        adr[16:9] = io_i;
      if (k == 2)
        adr[23:17] = io_i[6:0];
      na++;
      col = (cmd == 8'h50) ? 512 + int'(adr[3:0]) : int'({half, adr[7:0]});
      if (cmd == 8'h90)
        col = 0;
      if (k == 2 && cmd != 8'h80 && cmd != 8'h60)
        start_busy(LOAD_NS, 1'b1);
      if (k == 2)
        half = 1'b0;
    end
    else if (!ce_n_i && cmd == 8'h80 && col < 528)
    begin
      preg[col] = io_i;
      col++;
    end
  end

  // Each read strobe fall puts out one byte and steps the column, which holds at 527
  always @(negedge read_strobe_n_i)
  begin
    if (!ce_n_i && cmd == 8'h90)
      dout = (col == 0) ? ID0 : ID1;
    if (!ce_n_i && cmd != 8'h90 && cmd != 8'h70)
      dout = preg[col];
    if (!ce_n_i && col < 527)
      col++;
  end
endmodule // nfc_flash_model

/* sim/test_nfc_host_ctrl.sv */
// Self-checking bench of the NAND flash host controller against a flash model
`timescale 1ns/1ps
module test_nfc_host_ctrl;
  import nfc_pkg::*;
  localparam logic [7:0] ID_A = 8'h3c; // Arbitrary value
  localparam logic [7:0] ID_B = 8'h5a; // Arbitrary value
  localparam logic [7:0] STAT = 8'hc0;
  localparam logic [23:0] AD = 24'hfe7e10;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid = 1'b0;
  nfc_op_t cmd_op = OP_READ;
  logic [23:0] cmd_addr = 24'h000000;
  logic [9:0] cmd_len = 10'h000;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic spare_en = 1'b1;
  logic wr_en = 1'b1;
  logic cmd_ready, wr_ready, rd_valid, done, err, ce_n, cle, ale, we_n, rd_strobe_n, wp_n;
  logic spare_off, io_oe_n, rb;
  // Holds the ready line low to force a page load timeout
  logic rb_hold = 1'b0;
  logic [7:0] rd_data, io_h, io_f, io_bus;
  logic [7:0] rdq [$];
  logic [7:0] wbuf [$];
  int wr_idx = 0;
  logic got_done = 1'b0;
  logic ce_seen = 1'b0;
  int fails = 0;
  int check_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  // Whoever drives the bus wins; the model inverts when released
  assign io_bus = !io_oe_n ? io_h : io_f;

  nfc_host_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .cmd_ready_o(cmd_ready),
    .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .err_o(err), .spare_enable_i(spare_en),
    .write_enable_i(wr_en), .flash_ce_n_o(ce_n), .flash_cle_o(cle), .flash_ale_o(ale),
    .flash_we_n_o(we_n), .read_strobe_n_o(rd_strobe_n), .flash_wp_n_o(wp_n),
    .spare_area_select_o(spare_off), .flash_io_i(io_bus), .flash_io_o(io_h),
    .flash_io_oe_n_o(io_oe_n), .flash_rb_i(rb && !rb_hold));

  nfc_flash_model #(.ID0(ID_A), .ID1(ID_B), .STAT(STAT)) i_flash (.ce_n_i(ce_n),
    .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .read_strobe_n_i(rd_strobe_n), .wp_n_i(wp_n),
    .spare_off_i(spare_off), .io_i(io_bus), .io_o(io_f), .rb_o(rb));

  // Outputs sampled before the edge's own updates land
  always @(posedge clk_sys_i)
  begin
    if (rd_valid)
      rdq.push_back(rd_data);
    if (wr_valid && wr_ready)
      wr_idx++;
    if (done)
      got_done = 1'b1;
    if (!ce_n)
      ce_seen = 1'b1;
  end

  task automatic chk1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_q(input logic [7:0] e [$]);
    chk8(8'(rdq.size()), 8'(e.size()), "byte count");
    foreach (e[i])
      chk8(i < rdq.size() ? rdq[i] : 8'hxx, e[i], "read byte");
  endtask

  // One command, held until taken, program bytes fed on request
  task automatic run(input nfc_op_t op, input logic [23:0] a, input int n);
    int t;
    got_done = 1'b0;
    ce_seen = 1'b0;
    rdq.delete();
    wr_idx = 0;
    t = 0;
    @(negedge clk_sys_i);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = 10'(n);
    do @(posedge clk_sys_i); while (cmd_ready !== 1'b1 && t++ < 100);
    @(negedge clk_sys_i);
    cmd_valid = 1'b0;
    for (t = 0; t < 6000 && !got_done; t++)
    begin
      wr_valid = (wr_idx < wbuf.size());
      wr_data = wr_valid ? wbuf[wr_idx] : 8'h00;
      @(negedge clk_sys_i);
    end
    wr_valid = 1'b0;
    wbuf.delete();
    chk1(got_done, 1'b1, "done seen");
  endtask

  task automatic settle();
    repeat (4) @(negedge clk_sys_i);
  endtask

  task automatic t_prog_read();
    wbuf = '{8'h11, 8'ha5, 8'h5a, 8'hee};
    run(OP_PROGRAM, AD, 4);
    chk8(8'(wr_idx), 8'h04, "bytes taken");
    run(OP_READ, AD, 4);
    chk_q('{8'h11, 8'ha5, 8'h5a, 8'hee});
    $display("test prog_read ended");
  endtask

  task automatic t_half();
    run(OP_READ, AD | 24'h000100, 2);
    chk_q('{8'hff, 8'hff});
    wbuf = '{8'h3c};
    run(OP_PROGRAM, AD + 24'h8, 1);
    run(OP_READ, AD + 24'h8, 1);
    chk_q('{8'h3c});
    $display("test half ended");
  endtask

  task automatic t_erase_protect();
    run(OP_ERASE, AD, 0);
    chk1(err, 1'b0, "erase err");
    run(OP_READ, AD, 2);
    chk_q('{8'hff, 8'hff});
    wr_en = 1'b0;
    settle();
    chk1(wp_n, 1'b0, "protect pin");
    wbuf = '{8'h00};
    run(OP_PROGRAM, AD, 1);
    wr_en = 1'b1;
    settle();
    run(OP_READ, AD, 1);
    chk_q('{8'hff});
    $display("test erase_protect ended");
  endtask

  task automatic t_spare();
    spare_en = 1'b0;
    settle();
    chk1(spare_off, 1'b1, "spare pin off");
    run(OP_SPARE, AD, 2);
    chk1(err, 1'b1, "spare refused");
    chk1(ce_seen, 1'b0, "no pin activity");
    spare_en = 1'b1;
    settle();
    chk1(spare_off, 1'b0, "spare pin on");
    run(OP_SPARE, AD, 2);
    chk1(err, 1'b0, "spare err");
    chk_q('{8'hff, 8'hff});
    $display("test spare ended");
  endtask

  task automatic t_misc();
    run(OP_IDENT, 24'h000000, 2);
    chk_q('{ID_A, ID_B});
    run(OP_STATUS, 24'h000000, 1);
    chk_q('{STAT});
    run(OP_RESET, 24'h000000, 0);
    chk1(err, 1'b0, "reset err");
    // Ready never seen: the page load wait must give up with an error
    rb_hold = 1'b1;
    run(OP_READ, AD, 2);
    chk1(err, 1'b1, "load timeout");
    chk8(8'(rdq.size()), 8'h00, "timeout bytes");
    rb_hold = 1'b0;
    settle();
    $display("test misc ended");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cut a hang short well past the expected run length
  initial
  begin
    #(800000);
    fails++;
    give_verdict();
  end

  initial
  begin
    repeat (16) @(negedge clk_sys_i);
    chk1(ce_n, 1'b1, "reset select");
    chk1(wp_n, 1'b0, "reset protect");
    chk1(cmd_ready, 1'b1, "reset ready");
    rst_i = 1'b0;
    settle();
    t_prog_read();
    t_half();
    t_erase_protect();
    t_spare();
    t_misc();
    give_verdict();
  end
endmodule // test_nfc_host_ctrl
